// ==== hot_line_pkg.sv ====
// Constants, register map and carrier types for the hot-line timer block.
// Assumes a 10 MHz clock and an external serial-bus decoder that presents
// register reads and writes as one-cycle strobes.
//
// Functional notes
// - Non-latching variant: config three bit 0 puts the alert onto the secondary alert pin.
// - Latch holds overheat when chosen remote exceeds limit; running fans full.
// - Config four bit 2 stops the hold from forcing fans full.
// - Hold stays until temp below limit and status-two bit 0 cleared.
// - Latching variant resets remote two limit to 136, remote one to 100.
// - Config four bits 1:0 pick shared pin role: hot, tach, GPIO, alert.
// - Hot role stays inactive until config three bit 1 is set.
// - Timer runs while hot line low, pauses high, adds across assertions.
// - Boost bit forces running fans full while line held low externally.
// - Boost only affects running fans: nonzero duty or auto above start.
// - Reading the timer register clears the accumulated total.
// - Timer saturates at full scale and holds until read.
// - Bit 0 flags first assertion; past 45.52 ms value counts 22.76 ms.
// - Read while low restarts from zero, bit 0 set; zero limit flags.
// - Timer above limit sets status-two bit 5 and raises the alert.
// - Mask-two bit 5 blocks the timer alert but the flag still sets.
// - Limit one alerts past 45.52 ms; zero alerts on first assertion.
// - Config five bits 5..7 drive hot line low on channel over its limit.
// - Timer also counts external low periods while device is not driving.
// - Config five bits 5..7 all zero leave hot line as pure input.
// - Boost bit zero leaves fan duties untouched by hot-line events.
// - Sticky status flags; a read clears only flags whose cause is gone.
// - Mask bits block only the alert; status flags still set.
package hot_line_pkg;

    localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
    localparam logic [7:0] HOT_LIMIT_R1_ADDR = 8'h6a;
    localparam logic [7:0] HOT_LIMIT_LOC_ADDR = 8'h6b;
    localparam logic [7:0] HOT_LIMIT_R2_ADDR = 8'h6c;
    localparam logic [7:0] INT_MASK_TWO_ADDR = 8'h75;
    localparam logic [7:0] CONFIG_THREE_ADDR = 8'h78;
    localparam logic [7:0] HOT_TIMER_ADDR = 8'h79;
    localparam logic [7:0] HOT_TIMER_LIMIT_ADDR = 8'h7a;
    localparam logic [7:0] CONFIG_FIVE_ADDR = 8'h7c;
    localparam logic [7:0] CONFIG_FOUR_ADDR = 8'h7d;

    // Field positions
    localparam int CFG3_ALERT_BIT = 0;
    localparam int CFG3_HOT_EN_BIT = 1;
    localparam int CFG3_BOOST_BIT = 2;
    localparam int CFG4_NO_HOLD_FANS_BIT = 2;
    localparam int CFG4_HOLD_SEL_BIT = 3;
    localparam int CFG5_DRIVE_LSB = 5;
    localparam int ST2_HOLD_BIT = 0;
    localparam int ST2_F4_HOT_BIT = 5;
    localparam logic [7:0] ALERT_SOURCES = 8'h21;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LIMIT_R1_LATCH_RESET = 8'h64;
    localparam logic [7:0] LIMIT_R2_LATCH_RESET = 8'h88;
    localparam logic [7:0] LIMIT_PLAIN_RESET = 8'h64;
    localparam logic [7:0] TIMER_FULL = 8'hff;

    // Tick timing
    localparam int CLK_KHZ = 10000;
    localparam int TICK_US = 22760;
    localparam int TICK_CYCLES = (TICK_US * CLK_KHZ) / 1000;

    typedef enum logic [1:0] {
        ROLE_HOT = 2'b00,
        ROLE_TACH = 2'b01,
        ROLE_GPIO = 2'b10,
        ROLE_ALERT = 2'b11
    } pinRole_e;

    // Temperatures carry two fraction bits: 0.25 degree per step
    typedef struct packed {
        logic [9:0] remote2;
        logic [9:0] local0;
        logic [9:0] remote1;
    } temps_s;

    typedef struct packed {
        logic [2:0] autoMode;
        logic [2:0] dutyNonZero;
        logic [2:0] aboveStart;
    } fanState_s;

endpackage

// ==== thermal_assert_timer.sv ====
// Hot-line timer, limit compare, overheat hold and shared pin routing.
// Assumes register strobes are one-cycle pulses from the serial-bus slave
// and that temperature readings are refreshed by the conversion logic.
`timescale 1ns/10ps
module thermal_assert_timer #(
    parameter int TICK_CYCLES = hot_line_pkg::TICK_CYCLES,
    parameter bit LATCH_VARIANT = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire hot_line_pkg::temps_s temps,
    input wire hot_line_pkg::fanState_s fans,
    input wire logic fourthFanTachFail,
    input wire logic sharedPinIn,
    output logic sharedPinOut,
    output logic sharedPinOe_n,
    output logic altPinOut,
    output logic altPinOe_n,
    output logic busAlert_n,
    output logic overheatHold,
    output logic [2:0] fanFullSpeed
);

    logic [7:0] mask2_r;
    logic [7:0] cfg3_r;
    logic [7:0] cfg4_r;
    logic [7:0] cfg5_r;
    logic [7:0] timerLimit_r;
    logic [7:0] limR1_r;
    logic [7:0] limLoc_r;
    logic [7:0] limR2_r;
    logic [7:0] status2_r;
    logic [7:0] units_r;
    logic seen_r;
    logic [31:0] pre_r;
    logic sync1_r;
    logic sync2_r;
    logic hold_r;
    logic drive_r;
    logic [1:0] driveDly_r;

    wire logic wrHit = regWr;
    wire logic rdTimer = regRd && regAddr == hot_line_pkg::HOT_TIMER_ADDR;
    wire logic rdStat = regRd && regAddr == hot_line_pkg::STATUS_TWO_ADDR;

    hot_line_pkg::pinRole_e role;
    assign role = hot_line_pkg::pinRole_e'(cfg4_r[1:0]);

    // Hot role is live only with the enable bit also set
    wire logic hotActive = role == hot_line_pkg::ROLE_HOT &&
        cfg3_r[hot_line_pkg::CFG3_HOT_EN_BIT];

    // Synchronised copy; only the second stage is used
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= sharedPinIn;
            sync2_r <= sync1_r;
        end
    end

    // Line is low whether we pull it or someone else does
    wire logic lineLow = hotActive && !sync2_r;
    // Own drive reaches lineLow two cycles late; mask with a matching copy
    wire logic extLow = lineLow && !driveDly_r[1];

    // Over-limit compares: exceeding by a quarter degree means strictly above
    wire logic overR1 = temps.remote1 > {limR1_r, 2'b00};
    wire logic overLoc = temps.local0 > {limLoc_r, 2'b00};
    wire logic overR2 = temps.remote2 > {limR2_r, 2'b00};

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask2_r <= hot_line_pkg::REG_RESET;
            cfg3_r <= hot_line_pkg::REG_RESET;
            cfg4_r <= hot_line_pkg::REG_RESET;
            cfg5_r <= hot_line_pkg::REG_RESET;
            timerLimit_r <= hot_line_pkg::REG_RESET;
            limLoc_r <= hot_line_pkg::LIMIT_PLAIN_RESET;
            if (LATCH_VARIANT) begin
                limR1_r <= hot_line_pkg::LIMIT_R1_LATCH_RESET;
                limR2_r <= hot_line_pkg::LIMIT_R2_LATCH_RESET;
            end else begin
                limR1_r <= hot_line_pkg::LIMIT_PLAIN_RESET;
                limR2_r <= hot_line_pkg::LIMIT_PLAIN_RESET;
            end
        end else if (wrHit) begin
            case (regAddr)
                hot_line_pkg::INT_MASK_TWO_ADDR: mask2_r <= regWrData;
                hot_line_pkg::CONFIG_THREE_ADDR: cfg3_r <= regWrData;
                hot_line_pkg::CONFIG_FOUR_ADDR: cfg4_r <= regWrData;
                hot_line_pkg::CONFIG_FIVE_ADDR: cfg5_r <= regWrData;
                hot_line_pkg::HOT_TIMER_LIMIT_ADDR: timerLimit_r <= regWrData;
                hot_line_pkg::HOT_LIMIT_R1_ADDR: limR1_r <= regWrData;
                hot_line_pkg::HOT_LIMIT_LOC_ADDR: limLoc_r <= regWrData;
                hot_line_pkg::HOT_LIMIT_R2_ADDR: limR2_r <= regWrData;
                default: ;
            endcase
        end
    end

    // Prescaler only advances during low time, so partial periods carry
    // over between assertions instead of being lost.
    wire logic tick = lineLow && pre_r == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
        end else if (rdTimer) begin
            pre_r <= '0;
        end else if (lineLow) begin
            pre_r <= tick ? '0 : pre_r + 32'd1;
        end
    end

    // Accumulated units of 22.76 ms, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            units_r <= '0;
            seen_r <= 1'b0;
        end else if (rdTimer) begin
            units_r <= '0;
            seen_r <= lineLow;
        end else begin
            if (lineLow) begin
                seen_r <= 1'b1;
            end
            if (tick && units_r != hot_line_pkg::TIMER_FULL) begin
                units_r <= units_r + 8'h01;
            end
        end
    end

    // Below two units only the first-assertion flag shows
    logic [7:0] timerView;
    always_comb begin
        if (units_r < 8'h02) begin
            timerView = {7'h00, seen_r};
        end else begin
            timerView = units_r;
        end
    end

    wire logic timerOver = timerView > timerLimit_r;
    wire logic f4Cause = hotActive ? timerOver :
        (role == hot_line_pkg::ROLE_TACH && fourthFanTachFail);

    // Overheat hold source is one remote channel
    wire logic holdSel = cfg4_r[hot_line_pkg::CFG4_HOLD_SEL_BIT];
    wire logic holdOver = holdSel ? overR2 : overR1;
    wire logic holdNotBelow = holdSel ?
        temps.remote2 >= {limR2_r, 2'b00} :
        temps.remote1 >= {limR1_r, 2'b00};

    // Sticky status: set wins over a read clear, and a read only clears
    // a flag whose cause has gone.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status2_r <= hot_line_pkg::REG_RESET;
        end else begin
            if (f4Cause) begin
                status2_r[hot_line_pkg::ST2_F4_HOT_BIT] <= 1'b1;
            end else if (rdStat) begin
                status2_r[hot_line_pkg::ST2_F4_HOT_BIT] <= 1'b0;
            end
            if (LATCH_VARIANT && holdOver) begin
                status2_r[hot_line_pkg::ST2_HOLD_BIT] <= 1'b1;
            end else if (rdStat && !holdNotBelow) begin
                status2_r[hot_line_pkg::ST2_HOLD_BIT] <= 1'b0;
            end
        end
    end

    // Hold releases only once the flag is gone and temperature is back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
        end else if (LATCH_VARIANT && holdOver) begin
            hold_r <= 1'b1;
        end else if (!status2_r[hot_line_pkg::ST2_HOLD_BIT] &&
                     !holdNotBelow) begin
            hold_r <= 1'b0;
        end
    end

    // Masks gate only the alert, never the flags
    wire logic alertCond = |(status2_r & ~mask2_r &
        hot_line_pkg::ALERT_SOURCES);

    // Output drive of the hot line per channel
    wire logic [2:0] chanOver = {overR2, overLoc, overR1};
    wire logic [2:0] driveEn = cfg5_r[hot_line_pkg::CFG5_DRIVE_LSB +: 3];
    wire logic hotDrive = hotActive &&
        |(driveEn & chanOver);

    // Shared pin: only hot and alert roles ever pull it low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_r <= 1'b0;
            sharedPinOut <= 1'b1;
            sharedPinOe_n <= 1'b1;
        end else begin
            case (role)
                hot_line_pkg::ROLE_HOT: begin
                    drive_r <= hotDrive;
                    sharedPinOut <= 1'b0;
                    sharedPinOe_n <= !hotDrive;
                end
                hot_line_pkg::ROLE_ALERT: begin
                    drive_r <= 1'b0;
                    sharedPinOut <= 1'b0;
                    sharedPinOe_n <= !alertCond;
                end
                default: begin
                    drive_r <= 1'b0;
                    sharedPinOut <= 1'b1;
                    sharedPinOe_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            driveDly_r <= 2'b00;
        end else begin
            driveDly_r <= {driveDly_r[0], drive_r};
        end
    end

    // Secondary pin: the hold on the latching variant, else optional alert
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            altPinOut <= 1'b1;
            altPinOe_n <= 1'b1;
        end else begin
            altPinOut <= 1'b0;
            if (LATCH_VARIANT) begin
                altPinOe_n <= !hold_r;
            end else begin
                altPinOe_n <= !(cfg3_r[hot_line_pkg::CFG3_ALERT_BIT] &&
                    alertCond);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busAlert_n <= 1'b1;
            overheatHold <= 1'b0;
        end else begin
            busAlert_n <= !alertCond;
            overheatHold <= hold_r;
        end
    end

    // Fan override: boost needs an externally pulled low line; a fan that
    // is stopped is never started by either cause.
    wire logic [2:0] running = (fans.autoMode & fans.aboveStart) |
        (~fans.autoMode & fans.dutyNonZero);
    wire logic boostReq = cfg3_r[hot_line_pkg::CFG3_BOOST_BIT] &&
        extLow;
    wire logic holdReq = hold_r &&
        !cfg4_r[hot_line_pkg::CFG4_NO_HOLD_FANS_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fanFullSpeed <= 3'h0;
        end else begin
            fanFullSpeed <= running & {3{boostReq || holdReq}};
        end
    end

    // Read data is registered: it appears the cycle after the strobe and
    // shows the value before any clear-on-read.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                hot_line_pkg::STATUS_TWO_ADDR: regRdData <= status2_r;
                hot_line_pkg::INT_MASK_TWO_ADDR: regRdData <= mask2_r;
                hot_line_pkg::CONFIG_THREE_ADDR: regRdData <= cfg3_r;
                hot_line_pkg::CONFIG_FOUR_ADDR: regRdData <= cfg4_r;
                hot_line_pkg::CONFIG_FIVE_ADDR: regRdData <= cfg5_r;
                hot_line_pkg::HOT_TIMER_ADDR: regRdData <= timerView;
                hot_line_pkg::HOT_TIMER_LIMIT_ADDR: regRdData <= timerLimit_r;
                hot_line_pkg::HOT_LIMIT_R1_ADDR: regRdData <= limR1_r;
                hot_line_pkg::HOT_LIMIT_LOC_ADDR: regRdData <= limLoc_r;
                hot_line_pkg::HOT_LIMIT_R2_ADDR: regRdData <= limR2_r;
                default: regRdData <= 8'h00;
            endcase
        end
    end

endmodule

// ==== thermal_assert_timer_properties.sv ====
// Checker for the hot-line timer, bound to its top module.
// Assumes registers change only through regWr strobes.
`timescale 1ns/10ps
module thermal_assert_timer_check #(
    parameter int TICK_CYCLES = hot_line_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire hot_line_pkg::fanState_s fans,
    input wire logic sharedPinOut,
    input wire logic sharedPinOe_n,
    input wire logic altPinOe_n,
    input wire logic busAlert_n,
    input wire logic overheatHold,
    input wire logic [2:0] fanFullSpeed
);
    logic [7:0] cfg3_r, cfg4_r, cfg5_r, mask2_r;
    logic seen42_r;
    logic quiet, masked, noDrive;
    logic [2:0] runNow;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg3_r <= 8'h00;
            cfg4_r <= 8'h00;
            cfg5_r <= 8'h00;
            mask2_r <= 8'h00;
        end else if (regWr) begin
            case (regAddr)
                8'h78: cfg3_r <= regWrData;
                8'h7d: cfg4_r <= regWrData;
                8'h7c: cfg5_r <= regWrData;
                8'h75: mask2_r <= regWrData;
                default: ;
            endcase
        end
    end
    // Remembers a status read since the hold last rose
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            seen42_r <= 1'b0;
        else if (!overheatHold)
            seen42_r <= 1'b0;
        else if (regRd && regAddr == 8'h42)
            seen42_r <= 1'b1;
    end
    assign runNow = (fans.autoMode & fans.aboveStart)
        | (~fans.autoMode & fans.dutyNonZero);
    assign quiet = !cfg3_r[2] && (cfg4_r[2] || !overheatHold);
    assign masked = mask2_r[0] && mask2_r[5];
    assign noDrive = cfg5_r[7:5] == 3'b000 && cfg4_r[1:0] == 2'b00;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_no_drive;
        noDrive && $past(noDrive) |-> sharedPinOe_n;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("hot line driven with driving disabled");
    property p_drive_low;
        !sharedPinOe_n |-> !sharedPinOut;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("enabled pin not driven low");
    property p_fan_run;
        fanFullSpeed != 3'b000 |-> (fanFullSpeed & ~$past(runNow)) == 3'b000;
    endproperty
    a_fan_run: assert property (p_fan_run)
        else $error("full speed on a stopped fan");
    property p_fan_quiet;
        quiet && $past(quiet) |-> fanFullSpeed == 3'b000;
    endproperty
    a_fan_quiet: assert property (p_fan_quiet)
        else $error("fans forced with boost and hold forcing off");
    property p_mask;
        masked && $past(masked) |-> busAlert_n;
    endproperty
    a_mask: assert property (p_mask)
        else $error("alert raised while its sources are masked");
    property p_hold_release;
        $fell(overheatHold) |-> seen42_r;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("hold released without a status read");
    property p_alt_hold;
        $stable(overheatHold) |-> altPinOe_n == !overheatHold;
    endproperty
    a_alt_hold: assert property (p_alt_hold)
        else $error("secondary pin does not follow the hold");
    property p_cfg_read;
        regRd && regAddr == 8'h78 |=> regRdData == $past(cfg3_r);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config three reads back wrong");
    c_boost: cover property (fanFullSpeed != 3'b000);
    c_alert: cover property ($fell(busAlert_n));
    c_hold: cover property ($rose(overheatHold));
endmodule
bind thermal_assert_timer thermal_assert_timer_check #(
    .TICK_CYCLES(TICK_CYCLES)
) thermal_assert_timer_check_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .fans(fans),
    .sharedPinOut(sharedPinOut), .sharedPinOe_n(sharedPinOe_n),
    .altPinOe_n(altPinOe_n), .busAlert_n(busAlert_n),
    .overheatHold(overheatHold), .fanFullSpeed(fanFullSpeed)
);

// ==== cpu_hot_model.sv ====
// Processor-hot source that pulls the shared hot line low.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/10ps
module cpu_hot_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [15:0] len,
    output logic pullLow
);
    logic [15:0] left_r;
    // Releases between pulses so the pull-up, not a stale value, sets it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            left_r <= 16'h0000;
        else if (go)
            left_r <= len;
        else if (left_r != 16'h0000)
            left_r <= left_r - 16'h0001;
    end
    assign pullLow = left_r != 16'h0000;
endmodule

// ==== thermal_assert_timer_test.sv ====
// Self-checking bench for the hot-line timer block.
// Assumes the package and the processor-hot model are compiled first.
`timescale 1ns/10ps
module thermal_assert_timer_test;
    localparam logic [15:0] RST_TAB [11] = '{16'h7800, 16'h7a00, 16'h7c00,
        16'h7d00, 16'h7500, 16'h7900, 16'h4200, 16'h6a64, 16'h6b64,
        16'h6c88, 16'h1000};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic tachFail = 1'b0;
    logic go = 1'b0;
    logic [15:0] len = 16'h0000;
    hot_line_pkg::temps_s temps = '0;
    hot_line_pkg::fanState_s fans = '0;
    logic [7:0] regRdData;
    logic shOut, shOe_n, altOut, altOe_n, busAlert_n, overheatHold, extLow;
    logic [2:0] fanFullSpeed;
    logic [2:0] run;
    logic [31:0] rnd;
    logic rdPend = 1'b0;
    logic [15:0] expQ [$];
    int mismatches = 0;
    int total_checks = 0;
    int seed = 9581;
    wire hotLine = !(extLow || (!shOe_n && !shOut));
    always #50 clk = ~clk;
    thermal_assert_timer #(.TICK_CYCLES(10)) thermal_assert_timer_i (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .temps(temps),
        .fans(fans), .fourthFanTachFail(tachFail), .sharedPinIn(hotLine),
        .sharedPinOut(shOut), .sharedPinOe_n(shOe_n), .altPinOut(altOut),
        .altPinOe_n(altOe_n), .busAlert_n(busAlert_n),
        .overheatHold(overheatHold), .fanFullSpeed(fanFullSpeed));
    cpu_hot_model cpu_hot_model_i (.clk(clk), .rst_n(rst_n), .go(go),
        .len(len), .pullLow(extLow));
    task automatic check(input string nm, input logic [7:0] seen, e,
        input logic [7:0] m = 8'hff);
        total_checks++;
        if ((seen & m) !== (e & m)) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic finish_test;
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e, input logic [7:0] m = 8'hff);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back({m, e});
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic start(input int n);
        @(posedge clk);
        len <= n[15:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic pulse(input int n);
        start(n);
        cyc(n + 6);
    endtask
    // Read data stands from the edge after the strobe
    always @(posedge clk) begin
        rdPend <= regRd;
        if (rdPend && expQ.size() > 0) begin
            check("regRdData", regRdData, expQ[0][7:0],
                expQ[0][15:8]);
            void'(expQ.pop_front());
        end
    end
    initial begin
        cyc(50000);
        mismatches++;
        finish_test();
    end
    initial begin
        cyc(20);
        rst_n <= 1'b1;
        foreach (RST_TAB[i]) rd(RST_TAB[i][15:8], RST_TAB[i][7:0]);
        wr(8'h7a, 8'ha5);
        rd(8'h7a, 8'ha5);
        wr(8'h79, 8'h33);
        rd(8'h79, 8'h00);
        wr(8'h7a, 8'h00);
        pulse(50);
        rd(8'h79, 8'h00);
        wr(8'h78, 8'h02);
        pulse(15);
        pulse(30);
        rd(8'h79, 8'h04);
        rd(8'h79, 8'h00);
        pulse(3);
        rd(8'h79, 8'h01);
        pulse(2600);
        rd(8'h79, 8'hff);
        rd(8'h79, 8'h00);
        check("busAlert_n", 8'(busAlert_n), 8'h00);
        rd(8'h42, 8'h20, 8'h20);
        rd(8'h42, 8'h00, 8'h20);
        cyc(3);
        check("busAlert_n", 8'(busAlert_n), 8'h01);
        start(200);
        cyc(40);
        rd(8'h79, 8'h00, 8'h00);
        cyc(3);
        rd(8'h79, 8'h01);
        cyc(3);
        rd(8'h42, 8'h20, 8'h20);
        wr(8'h75, 8'h21);
        cyc(4);
        check("busAlert_n", 8'(busAlert_n), 8'h01);
        rd(8'h42, 8'h20, 8'h20);
        cyc(200);
        wr(8'h75, 8'h00);
        rd(8'h79, 8'h00, 8'h00);
        rd(8'h42, 8'h00, 8'h00);
        wr(8'h7a, 8'h01);
        pulse(8);
        check("busAlert_n", 8'(busAlert_n), 8'h01);
        pulse(30);
        check("busAlert_n", 8'(busAlert_n), 8'h00);
        rd(8'h79, 8'h00, 8'h00);
        rd(8'h42, 8'h20, 8'h20);
        wr(8'h7a, 8'h00);
        wr(8'h78, 8'h06);
        for (int k = 0; k < 5; k++) begin
            rnd = $random(seed);
            fans <= rnd[8:0];
            cyc(2);
            run = (fans.autoMode & fans.aboveStart)
                | (~fans.autoMode & fans.dutyNonZero);
            start(30);
            cyc(12);
            check("fanFullSpeed", 8'(fanFullSpeed), 8'(run));
            cyc(30);
            check("fanFullSpeed", 8'(fanFullSpeed), 8'h00);
        end
        wr(8'h78, 8'h02);
        fans <= 9'h1ff;
        start(30);
        cyc(12);
        check("fanFullSpeed", 8'(fanFullSpeed), 8'h00);
        cyc(30);
        temps.remote1 <= 10'h191;
        cyc(6);
        check("sharedPinOe_n", 8'(shOe_n), 8'h01);
        check("overheatHold", 8'(overheatHold), 8'h01);
        check("fanFullSpeed", 8'(fanFullSpeed), 8'h07);
        check("altPinOe_n", 8'(altOe_n), 8'h00);
        check("altPinOut", 8'(altOut), 8'h00);
        wr(8'h7c, 8'h20);
        cyc(3);
        check("hotLine", 8'(hotLine), 8'h00);
        temps.remote1 <= 10'h18f;
        cyc(6);
        check("sharedPinOe_n", 8'(shOe_n), 8'h01);
        check("overheatHold", 8'(overheatHold), 8'h01);
        rd(8'h42, 8'h01, 8'h01);
        cyc(4);
        check("overheatHold", 8'(overheatHold), 8'h00);
        check("altPinOe_n", 8'(altOe_n), 8'h01);
        wr(8'h7d, 8'h04);
        temps.remote1 <= 10'h191;
        cyc(6);
        check("overheatHold", 8'(overheatHold), 8'h01);
        check("fanFullSpeed", 8'(fanFullSpeed), 8'h00);
        wr(8'h7d, 8'h01);
        rd(8'h42, 8'h00, 8'h00);
        cyc(3);
        check("sharedPinOe_n", 8'(shOe_n), 8'h01);
        rd(8'h42, 8'h00, 8'h20);
        tachFail <= 1'b1;
        cyc(3);
        rd(8'h42, 8'h20, 8'h20);
        tachFail <= 1'b0;
        wr(8'h7d, 8'h03);
        cyc(3);
        check("sharedPinOe_n", 8'(shOe_n), 8'h00);
        wr(8'h7d, 8'h02);
        cyc(3);
        check("sharedPinOe_n", 8'(shOe_n), 8'h01);
        cyc(5);
        if (expQ.size() != 0)
            mismatches++;
        finish_test();
    end
endmodule
